// File: shared/mmd_regs.vh
// Constants for the memory map decoder: ranges, field positions and reset values.
`ifndef MMD_REGS_VH
`define MMD_REGS_VH
`define MMD_FLASH_END_LARGE 16'hfbff
`define MMD_FLASH_END_HALF 16'h7fff
`define MMD_FLASH_END_16K 16'h3fff
`define MMD_FLASH_END_8K 16'h1fff
`define MMD_IRAM_LOWER_TOP 8'h7f
`define MMD_BANK_AREA_TOP 8'h1f
`define MMD_BIT_AREA_BASE 8'h20
`define MMD_BANK_SEL_LOW_POS 3
`define MMD_BANK_SEL_HIGH_POS 4
`define MMD_STACK_PTR_RESET 8'h07
`define MMD_AUX_END_FULL 16'h0fff
`define MMD_AUX_END_SMALL 16'h01ff
`define MMD_PAGE_MASK 8'h0f
`define MMD_VAR_LARGE 2'h0
`define MMD_VAR_HALF 2'h1
`define MMD_VAR_16K 2'h2
`define MMD_VAR_8K 2'h3
`endif

// File: verilog/mmd_stack_pointer.v
// Stack pointer register with push, pop and direct load.
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"
module mmd_stack_pointer (
   // Clock and reset.
   input wire core_clk_in,
   input wire resetn_in,
   // Stack requests.
   input wire push_in,
   input wire pop_in,
   input wire load_in,
   input wire [7:0] load_value_in,
   // Pointer state.
   output reg [7:0] stack_pointer_out,
   output wire [7:0] push_addr_out
);
   // The push target is one above the last used slot; wraps over all 256 bytes.
   assign push_addr_out = stack_pointer_out + 8'h01;
   // Pointer update; load beats push, push beats pop.
   always @(posedge core_clk_in) begin
      if (!resetn_in) begin
         stack_pointer_out <= `MMD_STACK_PTR_RESET;
      end else if (load_in) begin
         stack_pointer_out <= load_value_in;
      end else if (push_in) begin
         stack_pointer_out <= push_addr_out;
      end else if (pop_in) begin
         stack_pointer_out <= stack_pointer_out - 8'h01;
      end
   end
endmodule // mmd_stack_pointer
`default_nettype wire

// File: verilog/mmd_memory_map_decoder.v
// Memory map decoder: steers core accesses to flash, internal RAM, function registers, aux RAM.
// Function
// - Flash is one block from 0x0000 to 0xfbff or 0x7fff.
// - Top flash byte is the lock byte; program addresses above it are reserved.
// - Small variants have 16 kB or 8 kB flash, last byte is lock byte.
// - Code moves read flash; external moves reach aux RAM, writes may target flash.
// - Internal RAM is 256 bytes; lower 128 reachable directly and indirectly.
// - Above 0x7f, direct goes to function registers, indirect to upper RAM.
// - Bytes 0x00-0x1f are four banks of eight, bank chosen by status bits 3,4.
// - Indirect accesses take their address from register zero or one of current bank.
// - Bytes 0x20-0x2f hold 128 bits; bit 8k+n is bit n of byte 0x20+k.
// - Bit or byte access is chosen by operand type, not address.
// - Stack pointer holds last used slot; push writes pointer+1 then increments.
// - Reset sets the stack pointer to 0x07, first push lands at 0x08.
// - Stack may lie anywhere in internal RAM and span all 256 bytes.
// - Aux RAM of 4096 or 512 bytes reached by data pointer or page plus index.
// - Page register gives upper byte for 8-bit moves; low four bits writable.
// - Data pointer is 16 bits and gives the full address for 16-bit moves.
`timescale 1ns/1ps
`default_nettype none
`include "mmd_regs.vh"
module mmd_memory_map_decoder (
   // Clock and reset.
   input wire core_clk_in,
   input wire resetn_in,
   // Variant strap, held steady by the core's logic.
   input wire [1:0] variant_in,
   // Access request from the core.
   input wire req_in,
   input wire [2:0] access_type_in,
   input wire write_in,
   input wire [15:0] addr_in,
   input wire [2:0] reg_num_in,
   input wire index_sel_in,
   input wire [7:0] index_value_in,
   input wire flash_write_enable_in,
   input wire instr_end_in,
   // Stack requests.
   input wire push_in,
   input wire pop_in,
   input wire stack_load_in,
   input wire [7:0] stack_load_value_in,
   // Register writes.
   input wire status_write_in,
   input wire [7:0] status_value_in,
   input wire page_write_in,
   input wire [7:0] page_value_in,
   input wire pointer_write_in,
   input wire [15:0] pointer_value_in,
   // Decoded target.
   output reg sel_flash_out,
   output reg sel_iram_out,
   output reg sel_func_reg_out,
   output reg sel_aux_out,
   output reg sel_reserved_out,
   output reg sel_lock_byte_out,
   output reg flash_write_out,
   output reg bit_access_out,
   output reg [2:0] bit_pos_out,
   output reg [15:0] target_addr_out,
   // Register views.
   output reg [7:0] stack_pointer_out,
   output reg [7:0] program_status_word_out,
   output reg [7:0] aux_ram_page_select_out,
   output reg [15:0] data_pointer_out
);
   // Access types from the core.
   localparam T_CODE = 3'h0;
   localparam T_DIRECT = 3'h1;
   localparam T_INDIRECT = 3'h2;
   localparam T_REG = 3'h3;
   localparam T_BIT = 3'h4;
   localparam T_EXT16 = 3'h5;
   localparam T_EXT8 = 3'h6;
   localparam T_STACK = 3'h7;

   // Highest flash byte for each variant, which is also the lock byte.
   function [15:0] mmd_flash_end;
      input [1:0] v;
      begin
         case (v)
            `MMD_VAR_LARGE: mmd_flash_end = `MMD_FLASH_END_LARGE;
            `MMD_VAR_HALF: mmd_flash_end = `MMD_FLASH_END_HALF;
            `MMD_VAR_16K: mmd_flash_end = `MMD_FLASH_END_16K;
            default: mmd_flash_end = `MMD_FLASH_END_8K;
         endcase
      end
   endfunction

   // Register address inside the active bank.
   function [7:0] mmd_bank_addr;
      input [1:0] bank;
      input [2:0] r;
      begin
         mmd_bank_addr = {3'h0, bank, r};
      end
   endfunction

   wire [7:0] stack_now;
   wire [7:0] stack_push_addr;
   reg [1:0] active_bank;
   reg [1:0] pending_bank;
   reg bank_pending;
   reg [15:0] flash_end;
   reg [15:0] aux_end;
   reg next_flash;
   reg next_iram;
   reg next_func_reg;
   reg next_aux;
   reg next_reserved;
   reg next_lock;
   reg next_fwrite;
   reg next_bit;
   reg [2:0] next_bit_pos;
   reg [15:0] next_addr;
   reg [15:0] ext_addr;

   // Stack pointer keeper.
   mmd_stack_pointer u_stack (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .push_in(push_in),
      .pop_in(pop_in),
      .load_in(stack_load_in),
      .load_value_in(stack_load_value_in),
      .stack_pointer_out(stack_now),
      .push_addr_out(stack_push_addr)
   );

   // Bank bits are held back until the instruction ends, so the writing
   // instruction's own register accesses still use the old bank.
   always @(posedge core_clk_in) begin
      if (!resetn_in) begin
         active_bank <= 2'h0;
         pending_bank <= 2'h0;
         bank_pending <= 1'b0;
      end else begin
         if (status_write_in) begin
            pending_bank <= {status_value_in[`MMD_BANK_SEL_HIGH_POS],
                             status_value_in[`MMD_BANK_SEL_LOW_POS]};
            bank_pending <= 1'b1;
         end else if (instr_end_in && bank_pending) begin
            bank_pending <= 1'b0;
         end
         if (instr_end_in && bank_pending && !status_write_in) begin
            active_bank <= pending_bank;
         end
      end
   end

   // Combinational decode of the current access.
   always @* begin
      flash_end = mmd_flash_end(variant_in);
      aux_end = (variant_in[1]) ? `MMD_AUX_END_SMALL : `MMD_AUX_END_FULL;
      ext_addr = (access_type_in == T_EXT16) ? data_pointer_out :
         {aux_ram_page_select_out, index_value_in};
      next_flash = 1'b0;
      next_iram = 1'b0;
      next_func_reg = 1'b0;
      next_aux = 1'b0;
      next_reserved = 1'b0;
      next_lock = 1'b0;
      next_fwrite = 1'b0;
      next_bit = 1'b0;
      next_bit_pos = 3'h0;
      next_addr = addr_in;
      case (access_type_in)
         T_CODE: begin
            // Code moves and fetches read program flash up to the lock byte; addresses above it are reserved.
            if (addr_in > flash_end) begin
               next_reserved = 1'b1;
            end else begin
               next_flash = 1'b1;
               next_lock = (addr_in == flash_end);
            end
         end
         T_DIRECT: begin
            next_addr = {8'h00, addr_in[7:0]};
            if (addr_in[7:0] > `MMD_IRAM_LOWER_TOP) begin
               next_func_reg = 1'b1;
            end else begin
               next_iram = 1'b1;
            end
         end
         T_INDIRECT: begin
            // Index register value is the address; upper half is the separate RAM.
            next_iram = 1'b1;
            next_addr = {8'h00, index_value_in};
         end
         T_REG: begin
            next_iram = 1'b1;
            next_addr = {8'h00, mmd_bank_addr(active_bank, reg_num_in)};
         end
         T_BIT: begin
            // Chosen by operand type only, never by address.
            next_bit = 1'b1;
            next_bit_pos = addr_in[2:0];
            if (addr_in[7]) begin
               next_func_reg = 1'b1;
               next_addr = {8'h00, addr_in[7:3], 3'h0};
            end else begin
               next_iram = 1'b1;
               next_addr = {8'h00, `MMD_BIT_AREA_BASE + {4'h0, addr_in[6:3]}};
            end
         end
         T_EXT16, T_EXT8: begin
            next_addr = ext_addr;
            if (write_in && flash_write_enable_in) begin
               next_fwrite = 1'b1;
               next_flash = (ext_addr <= flash_end);
               next_reserved = (ext_addr > flash_end);
               next_lock = (ext_addr == flash_end);
            end else if (ext_addr <= aux_end) begin
               next_aux = 1'b1;
            end else begin
               next_reserved = 1'b1;
            end
         end
         T_STACK: begin
            // Push writes above the last used slot; pop reads the slot itself.
            next_iram = 1'b1;
            next_addr = {8'h00, (write_in ? stack_push_addr : stack_now)};
         end
         default: begin
            next_reserved = 1'b1;
         end
      endcase
      if (!req_in) begin
         next_flash = 1'b0;
         next_iram = 1'b0;
         next_func_reg = 1'b0;
         next_aux = 1'b0;
         next_reserved = 1'b0;
         next_lock = 1'b0;
         next_fwrite = 1'b0;
         next_bit = 1'b0;
      end
   end

   // Registered outputs and software-visible registers.
   always @(posedge core_clk_in) begin
      if (!resetn_in) begin
         sel_flash_out <= 1'b0;
         sel_iram_out <= 1'b0;
         sel_func_reg_out <= 1'b0;
         sel_aux_out <= 1'b0;
         sel_reserved_out <= 1'b0;
         sel_lock_byte_out <= 1'b0;
         flash_write_out <= 1'b0;
         bit_access_out <= 1'b0;
         bit_pos_out <= 3'h0;
         target_addr_out <= 16'h0000;
         stack_pointer_out <= `MMD_STACK_PTR_RESET;
         program_status_word_out <= 8'h00;
         aux_ram_page_select_out <= 8'h00;
         data_pointer_out <= 16'h0000;
      end else begin
         sel_flash_out <= next_flash;
         sel_iram_out <= next_iram;
         sel_func_reg_out <= next_func_reg;
         sel_aux_out <= next_aux;
         sel_reserved_out <= next_reserved;
         sel_lock_byte_out <= next_lock;
         flash_write_out <= next_fwrite;
         bit_access_out <= next_bit;
         bit_pos_out <= next_bit_pos;
         target_addr_out <= next_addr;
         stack_pointer_out <= stack_now;
         if (status_write_in) begin
            program_status_word_out <= status_value_in;
         end
         if (page_write_in) begin
            aux_ram_page_select_out <= page_value_in & `MMD_PAGE_MASK;
         end
         if (pointer_write_in) begin
            data_pointer_out <= pointer_value_in;
         end
      end
   end
endmodule // mmd_memory_map_decoder
`default_nettype wire

// File: test/mmd_assertions.sv
// Port-level checks for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module mmd_assertions (
   // Clock, reset and strap.
   input wire logic core_clk_in, resetn_in,
   input wire logic [1:0] variant_in,
   // Requests and register writes.
   input wire logic req_in, write_in, push_in, page_write_in, pointer_write_in,
   input wire logic [2:0] access_type_in,
   input wire logic [15:0] addr_in,
   input wire logic [7:0] index_value_in, page_value_in,
   // Decoded outputs and register views.
   input wire logic sel_flash_out, sel_iram_out, sel_func_reg_out, sel_reserved_out,
   input wire logic sel_lock_byte_out, bit_access_out,
   input wire logic [2:0] bit_pos_out,
   input wire logic [15:0] target_addr_out, data_pointer_out,
   input wire logic [7:0] stack_pointer_out, aux_ram_page_select_out
);
   // Last flash byte of the strapped variant, which is also the lock byte.
   wire [15:0] fend = variant_in[1] ? (variant_in[0] ? 16'h1fff : 16'h3fff)
      : (variant_in[0] ? 16'h7fff : 16'hfbff);
   // Valid flag beside the type, so one compare names a live request of one kind.
   wire [3:0] op = {req_in, access_type_in};
   default clocking @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);
   a_code_flash: assert property (op == 4'h8 && addr_in <= fend |=> sel_flash_out)
      else $error("code fetch not in flash");
   a_code_reserved: assert property (op == 4'h8 |=>
      sel_reserved_out == ($past(addr_in) > $past(fend))) else $error("reserved decode wrong");
   a_lock_byte: assert property (op == 4'h8 |=>
      sel_lock_byte_out == ($past(addr_in) == $past(fend))) else $error("lock byte decode wrong");
   a_direct_split: assert property (op == 4'h9 |=>
      sel_func_reg_out == $past(addr_in[7]) && sel_iram_out != $past(addr_in[7]))
      else $error("direct split wrong");
   a_indirect_ram: assert property (op == 4'ha |=>
      sel_iram_out && target_addr_out == {8'h00, $past(index_value_in)})
      else $error("indirect target wrong");
   a_bit_map: assert property (op == 4'hc && !addr_in[7] |=> bit_access_out &&
      bit_pos_out == $past(addr_in[2:0]) && target_addr_out == {12'h002, $past(addr_in[6:3])})
      else $error("bit address map wrong");
   a_ext16_pointer: assert property (op == 4'hd && !pointer_write_in |=>
      target_addr_out == $past(data_pointer_out)) else $error("pointer address wrong");
   a_ext8_page: assert property (op == 4'he && !page_write_in |=>
      target_addr_out == {$past(aux_ram_page_select_out), $past(index_value_in)})
      else $error("paged address wrong");
   a_page_mask: assert property (page_write_in |=>
      aux_ram_page_select_out == ($past(page_value_in) & 8'h0f)) else $error("page mask wrong");
   a_push_slot: assert property (op == 4'hf && write_in && push_in |=> ##1
      {8'h00, stack_pointer_out} == $past(target_addr_out)) else $error("push slot wrong");
   a_stack_reset: assert property ($rose(resetn_in) |-> stack_pointer_out == 8'h07)
      else $error("pointer reset value wrong");
endmodule // mmd_assertions
bind mmd_memory_map_decoder mmd_assertions mmd_assertions_inst (.*);
`default_nettype wire

// File: test/mmd_core_model.sv
// Core-side model that issues single memory requests.
`timescale 1ns/1ps
`default_nettype none
module mmd_core_model (
   // Clock.
   input wire logic core_clk_in,
   // Request lines towards the decoder.
   output logic req_out,
   output logic [2:0] type_out,
   output logic write_out,
   output logic push_out,
   output logic [15:0] addr_out,
   output logic [7:0] index_out
);
   // Idle from time zero.
   initial begin
      {req_out, type_out, write_out, push_out, addr_out, index_out} = 30'h0;
   end
   // Hold one request across the taking edge; afterwards the operands turn to their inverse,
   // so a decoder that samples late cannot pass on stale values.
   task automatic issue(input logic [2:0] t, input logic w, p, input logic [15:0] a,
      input logic [7:0] x);
      @(posedge core_clk_in);
      #1;
      {req_out, type_out, write_out, push_out, addr_out, index_out} = {1'b1, t, w, p, a, x};
      @(posedge core_clk_in);
      #1;
      {req_out, push_out, addr_out, index_out} = {2'b00, ~a, ~x};
   endtask
endmodule // mmd_core_model
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the memory map decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // One access with the selects {flash,iram,func,aux,reserved,lock} and target it gives.
   typedef struct packed {
      logic [1:0] v;
      logic [2:0] t;
      logic [15:0] a;
      logic [7:0] x;
      logic [5:0] s;
      logic [15:0] g;
   } mmd_row_t;
   logic core_clk_in, resetn_in, req_in, write_in, push_in, index_sel_in, pop_in;
   logic flash_write_enable_in, sel_flash_out, sel_iram_out, sel_func_reg_out, sel_aux_out;
   logic sel_reserved_out, sel_lock_byte_out, flash_write_out, bit_access_out;
   logic [1:0] variant_in;
   logic [2:0] access_type_in, reg_num_in, bit_pos_out;
   logic [4:0] strobe;
   logic [7:0] index_value_in, stack_pointer_out, program_status_word_out;
   logic [7:0] aux_ram_page_select_out;
   logic [15:0] addr_in, value, target_addr_out, data_pointer_out;
   int n_errors = 0;
   int cmp_count = 0;
   wire [5:0] sel = {sel_flash_out, sel_iram_out, sel_func_reg_out, sel_aux_out, sel_reserved_out,
      sel_lock_byte_out};
   mmd_row_t rows[12] = '{
      '{2'h0, 3'h0, 16'hfbff, 8'h00, 6'h21, 16'hfbff},
      '{2'h0, 3'h0, 16'hfc00, 8'h00, 6'h02, 16'hfc00},
      '{2'h1, 3'h0, 16'h8000, 8'h00, 6'h02, 16'h8000},
      '{2'h2, 3'h0, 16'h3fff, 8'h00, 6'h21, 16'h3fff},
      '{2'h3, 3'h0, 16'h2000, 8'h00, 6'h02, 16'h2000},
      '{2'h0, 3'h1, 16'h007f, 8'h00, 6'h10, 16'h007f},
      '{2'h0, 3'h1, 16'h0080, 8'h00, 6'h08, 16'h0080},
      '{2'h0, 3'h2, 16'h0000, 8'h80, 6'h10, 16'h0080},
      '{2'h0, 3'h4, 16'h0013, 8'h00, 6'h10, 16'h0022},
      '{2'h0, 3'h1, 16'h0013, 8'h00, 6'h10, 16'h0013},
      '{2'h0, 3'h4, 16'h00d3, 8'h00, 6'h08, 16'h00d0},
      '{2'h0, 3'h6, 16'h0000, 8'h34, 6'h04, 16'h0034}};
   mmd_memory_map_decoder mmd_memory_map_decoder_inst (.*, .stack_load_value_in(value[7:0]),
      .status_value_in(value[7:0]), .page_value_in(value[7:0]), .pointer_value_in(value),
      .status_write_in(strobe[0]), .page_write_in(strobe[1]), .pointer_write_in(strobe[2]),
      .stack_load_in(strobe[3]), .instr_end_in(strobe[4]));
   mmd_core_model mmd_core_model_inst (.core_clk_in(core_clk_in), .req_out(req_in),
      .type_out(access_type_in), .write_out(write_in), .push_out(push_in), .addr_out(addr_in),
      .index_out(index_value_in));
   // 20 MHz clock.
   initial begin
      core_clk_in = 1'b0;
      forever #25 core_clk_in = ~core_clk_in;
   end
   task automatic chk(input logic [15:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One-cycle write strobe: bit 0 status, 1 page, 2 pointer, 3 stack load, 4 boundary.
   task automatic pulse(input int k, input logic [15:0] v);
      @(posedge core_clk_in);
      #1;
      value = v;
      strobe = 5'h01 << k;
      @(posedge core_clk_in);
      #1;
      strobe = 5'h00;
   endtask
   // One access through the core model, then its decode as it stands for one cycle.
   task automatic acc(input logic [2:0] t, input logic w, p, input logic [15:0] a,
      input logic [7:0] x, input logic [5:0] s, input logic [15:0] g);
      mmd_core_model_inst.issue(t, w, p, a, x);
      chk({10'h0, sel}, {10'h0, s});
      chk(target_addr_out, g);
   endtask
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // The whole run is under a hundred cycles; this cuts a hung handshake short.
   initial begin
      #100us;
      n_errors++;
      summarize();
   end
   initial begin
      {resetn_in, index_sel_in, pop_in, flash_write_enable_in, strobe, value} = 25'h0;
      variant_in = 2'h0;
      reg_num_in = 3'h7;
      repeat (20) @(posedge core_clk_in);
      #1;
      resetn_in = 1'b1;
      foreach (rows[i]) begin
         variant_in = rows[i].v;
         acc(rows[i].t, 1'b0, 1'b0, rows[i].a, rows[i].x, rows[i].s, rows[i].g);
         chk({15'h0, bit_access_out}, {15'h0, rows[i].t == 3'h4});
         if (rows[i].t == 3'h4) chk({13'h0, bit_pos_out}, {13'h0, rows[i].a[2:0]});
      end
      // Register presets; none of the rows above writes a register.
      chk({8'h0, stack_pointer_out}, 16'h0007);
      chk({program_status_word_out, aux_ram_page_select_out}, 16'h0);
      chk(data_pointer_out, 16'h0);
      // First push lands in bank one; the pointer view follows a cycle later.
      acc(3'h7, 1'b1, 1'b1, 16'h0, 8'h0, 6'h10, 16'h0008);
      @(posedge core_clk_in);
      #1;
      chk({8'h0, stack_pointer_out}, 16'h0008);
      pulse(3, 16'h00fe);
      acc(3'h7, 1'b1, 1'b1, 16'h0, 8'h0, 6'h10, 16'h00ff);
      // A pop drops the pointer; a stack read then targets the top slot itself.
      @(posedge core_clk_in);
      #1;
      pop_in = 1'b1;
      @(posedge core_clk_in);
      #1;
      pop_in = 1'b0;
      acc(3'h7, 1'b0, 1'b0, 16'h0, 8'h0, 6'h10, 16'h00fe);
      chk({8'h0, stack_pointer_out}, 16'h00fe);
      // A bank change waits for the instruction boundary.
      pulse(0, 16'h0018);
      chk({8'h0, program_status_word_out}, 16'h0018);
      acc(3'h3, 1'b0, 1'b0, 16'h0, 8'h0, 6'h10, 16'h0007);
      pulse(4, 16'h0);
      acc(3'h3, 1'b0, 1'b0, 16'h0, 8'h0, 6'h10, 16'h001f);
      // Pointer at the last aux byte, one past it, then a write redirected to flash.
      pulse(2, 16'h0fff);
      acc(3'h5, 1'b0, 1'b0, 16'h0, 8'h0, 6'h04, 16'h0fff);
      pulse(2, 16'h1000);
      chk(data_pointer_out, 16'h1000);
      acc(3'h5, 1'b0, 1'b0, 16'h0, 8'h0, 6'h02, 16'h1000);
      flash_write_enable_in = 1'b1;
      mmd_core_model_inst.issue(3'h5, 1'b1, 1'b0, 16'h0, 8'h0);
      chk({15'h0, flash_write_out}, 16'h0001);
      flash_write_enable_in = 1'b0;
      // Page register keeps four bits; the small variant refuses page 0x0f.
      pulse(1, 16'h00ff);
      chk({8'h0, aux_ram_page_select_out}, 16'h000f);
      acc(3'h6, 1'b0, 1'b0, 16'h0, 8'h34, 6'h04, 16'h0f34);
      variant_in = 2'h3;
      acc(3'h6, 1'b0, 1'b0, 16'h0, 8'h34, 6'h02, 16'h0f34);
      // A second reset mid-run brings pointer, page and bank back to their presets.
      resetn_in = 1'b0;
      repeat (2) @(posedge core_clk_in);
      #1;
      resetn_in = 1'b1;
      chk({8'h0, stack_pointer_out}, 16'h0007);
      chk({8'h0, aux_ram_page_select_out}, 16'h0000);
      acc(3'h3, 1'b0, 1'b0, 16'h0, 8'h0, 6'h10, 16'h0007);
      summarize();
   end
endmodule // tb_top
`default_nettype wire
